// ---- rtl/gpio_notify.sv ----
// Operation
// - Function 000: all six pins are plain software pins.
// - Function 001: pin 4 is CTS input, pin 5 is RTS output, both low-active.
// - Function 010: pin 2 is DSR input, pin 3 is DTR output, both low-active.
// - Function 011: pin 5 drives transceiver direction for half-duplex RS-485.
// - Function 100: pin 5 drives direction only after a multidrop address match.
// - Function bit 3 selects direction pin level while transmitting.
// - Direction bit 0 makes a pin input, 1 makes it output.
// - A serial-function pin ignores its direction bit, which does not report it.
// - Set register write drives output pins high for ones, low for zeros.
// - Set register writes leave input pins alone.
// - Clear register write drives low outputs written one, others unchanged.
// - Status register reads the present level of every pin.
// - Unmasked pin changes raise a notification; masked ones do not.
// - Masking leaves status alone; extended-format packets always carry current pin levels.
// - Format bit 0 picks standard or extended notification data.
// - Packet is eight header bytes then two data bytes, fixed header values.
// - Index low byte is interface zero, high byte zero.
// - Standard data bits carry overrun, parity, framing, ring, break, DSR, carrier.
// - Ring and break are levels; error bits report an occurrence.
// - Extended layout places pin levels in bits 14,13,12,11,9,8.
// - After transmit ends, hold direction for programmed bit times.
//
// Design decisions made here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_notify_regs.svh"
module gpio_notify #(
	parameter int PINS = 6
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic reset_n,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Pins.
	input wire logic [PINS-1:0] pin_in,
	output logic [PINS-1:0] pin_out,
	output logic [PINS-1:0] pin_oe,
	// Serial engine side.
	output logic cts_level,
	output logic dsr_level,
	input wire logic rts_request,
	input wire logic dtr_request,
	input wire logic tx_active,
	input wire logic address_match,
	input wire logic bit_tick,
	output logic [2:0] flow_function,
	// Line events.
	input wire gpio_notify_pkg::line_state_type line_state,
	// Notification byte stream to the interrupt endpoint.
	input wire logic note_ready,
	output gpio_notify_pkg::note_byte_type note_out
);
	logic [3:0] function_sel;
	logic [PINS-1:0] direction;
	logic [PINS-1:0] out_level;
	logic [PINS-1:0] mask;
	logic format_ext;
	logic [3:0] turnaround_bit_times;
	logic [3:0] turn_count;
	logic transceiver_direction;
	logic pending;
	logic [2:0] error_seen;
	logic sending;
	logic [3:0] byte_index;
	logic [15:0] note_data;
	logic [PINS-1:0] pin_level;
	logic [PINS-1:0] pin_changed;

	pin_sync #(.WIDTH(PINS)) sync (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.pin_raw(pin_in),
		.pin_level(pin_level),
		.pin_changed(pin_changed)
	);

	// Which pins are taken by a serial-control function.
	wire [2:0] fn = function_sel[2:0];
	wire mode_rts = fn == `FN_RTS_CTS;
	wire mode_dtr = fn == `FN_DTR_DSR;
	wire mode_485 = fn == `FN_TRANSCEIVER_DIRECTION || fn == `FN_TRANSCEIVER_DIRECTION_ADDR;
	wire [PINS-1:0] taken = {mode_rts | mode_485, mode_rts, mode_dtr, mode_dtr, 2'b00};

	// Bus decode; an access completes in one cycle and unmapped reads return zero.
	wire access = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wr = access && wb_we_i && wb_sel_i[0];
	wire wr_function = wr && wb_adr_i == `OFS_FUNCTION;
	wire wr_direction = wr && wb_adr_i == `OFS_DIRECTION;
	wire wr_set = wr && wb_adr_i == `OFS_SET;
	wire wr_clear = wr && wb_adr_i == `OFS_CLEAR;
	wire wr_mask = wr && wb_adr_i == `OFS_MASK;
	wire wr_format = wr && wb_adr_i == `OFS_FORMAT;
	wire wr_turn = wr && wb_adr_i == `OFS_TURNAROUND;
	wire [PINS-1:0] wdata = wb_dat_i[PINS-1:0];
	wire [31:0] read_mux =
		wb_adr_i == `OFS_FUNCTION ? {28'h0, function_sel} :
		wb_adr_i == `OFS_DIRECTION ? {26'h0, direction & ~taken} :
		wb_adr_i == `OFS_SET ? {26'h0, out_level} :
		wb_adr_i == `OFS_STATUS ? {26'h0, pin_level} :
		wb_adr_i == `OFS_MASK ? {26'h0, mask} :
		wb_adr_i == `OFS_FORMAT ? {31'h0, format_ext} :
		wb_adr_i == `OFS_TURNAROUND ? {28'h0, turnaround_bit_times} :
		wb_adr_i == `OFS_LINE ? {25'h0, line_state} : 32'h00000000;

	// Output latch: set writes only touch output pins, clear writes only ones.
	wire [PINS-1:0] gp_out = direction & ~taken;
	wire [PINS-1:0] next_out_level =
		wr_set ? (out_level & ~gp_out) | (wdata & gp_out) :
		wr_clear ? out_level & ~(wdata & gp_out) : out_level;

	// Direction enable for RS-485, gated on address match in mode 100.
	wire tx_drive = tx_active && (fn != `FN_TRANSCEIVER_DIRECTION_ADDR || address_match);
	wire dir_active = tx_drive || turn_count != 4'h0;
	wire polarity = function_sel[`POLARITY_BIT];
	wire dir_pin = dir_active ? polarity : ~polarity;

	// Pin drive and enables.
	wire [PINS-1:0] fn_out = {mode_485 ? dir_pin : ~rts_request, 1'b0, ~dtr_request, 3'b000};
	wire [PINS-1:0] fn_oe = {mode_rts | mode_485, 1'b0, mode_dtr, 3'b000};
	wire [PINS-1:0] next_pin_out = (taken & fn_out) | (~taken & out_level);
	wire [PINS-1:0] next_pin_oe = (taken & fn_oe) | (~taken & direction);

	// Notification trigger: unmasked pin change or line error or level change.
	logic ring_q;
	logic break_q;
	logic dsr_q;
	logic carrier_q;
	wire line_change = (line_state.ring ^ ring_q) | (line_state.break_level ^ break_q) |
		(line_state.dsr ^ dsr_q) | (line_state.carrier ^ carrier_q);
	wire line_error = line_state.overrun | line_state.parity | line_state.framing;
	wire trigger = |(pin_changed & ~mask) || line_change || line_error;
	wire start = pending && !sending;

	// Data word captured at packet start from current levels.
	wire [15:0] std_data = {9'h000, error_seen | {line_state.overrun, line_state.parity,
		line_state.framing}, line_state.ring, line_state.break_level, line_state.dsr,
		line_state.carrier};
	wire [15:0] ext_data = {1'b0, pin_level[5], pin_level[4], pin_level[3], pin_level[0],
		1'b0, pin_level[2], pin_level[1], 1'b0, std_data[6:0]};
	wire [15:0] next_data = format_ext ? ext_data : std_data;

	// Packet byte selection; header words go out low byte first.
	wire [15:0] note_value = `NOTE_VALUE;
	wire [15:0] note_length = `NOTE_LENGTH;
	wire [7:0] packet_byte =
		byte_index == 4'h0 ? `NOTE_REQUEST_TYPE :
		byte_index == 4'h1 ? `NOTE_CODE :
		byte_index == 4'h2 ? note_value[7:0] :
		byte_index == 4'h3 ? note_value[15:8] :
		byte_index == 4'h4 ? `NOTE_INTERFACE :
		byte_index == 4'h5 ? 8'h00 :
		byte_index == 4'h6 ? note_length[7:0] :
		byte_index == 4'h7 ? note_length[15:8] :
		byte_index == 4'h8 ? note_data[7:0] : note_data[15:8];
	wire byte_taken = note_out.valid && note_ready;
	wire last_taken = byte_taken && byte_index == `NOTE_BYTES - 4'h1;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			function_sel <= `RESET_FUNCTION;
			direction <= `RESET_DIRECTION;
			mask <= `RESET_MASK;
			format_ext <= 1'b0;
			turnaround_bit_times <= `RESET_TURNAROUND;
		end else begin
			if (wr_function) begin
				function_sel <= wb_dat_i[3:0];
			end
			if (wr_direction) begin
				direction <= wdata;
			end
			if (wr_mask) begin
				mask <= wdata;
			end
			if (wr_format) begin
				format_ext <= wb_dat_i[`FORMAT_BIT];
			end
			if (wr_turn) begin
				turnaround_bit_times <= wb_dat_i[3:0];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			out_level <= `RESET_LEVELS;
			pin_out <= '0;
			pin_oe <= '0;
			cts_level <= 1'b1;
			dsr_level <= 1'b1;
			flow_function <= 3'h0;
		end else begin
			wb_ack_o <= access;
			wb_dat_o <= access ? read_mux : 32'h00000000;
			out_level <= next_out_level;
			pin_out <= next_pin_out;
			pin_oe <= next_pin_oe;
			cts_level <= mode_rts ? pin_level[4] : 1'b0;
			dsr_level <= mode_dtr ? pin_level[2] : 1'b0;
			flow_function <= fn;
		end
	end

	// Turn-around: reload while transmitting, count bit times after.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			turn_count <= 4'h0;
		end else if (!mode_485) begin
			turn_count <= 4'h0;
		end else if (tx_drive) begin
			turn_count <= turnaround_bit_times;
		end else if (bit_tick && turn_count != 4'h0) begin
			turn_count <= turn_count - 4'h1;
		end
	end

	// Sticky errors and pending flag; a new event wins over the clear at start.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pending <= 1'b0;
			error_seen <= 3'h0;
			ring_q <= 1'b0;
			break_q <= 1'b0;
			dsr_q <= 1'b0;
			carrier_q <= 1'b0;
		end else begin
			ring_q <= line_state.ring;
			break_q <= line_state.break_level;
			dsr_q <= line_state.dsr;
			carrier_q <= line_state.carrier;
			pending <= trigger || (pending && !start);
			error_seen <= {line_state.overrun, line_state.parity, line_state.framing} |
				(start ? 3'h0 : error_seen);
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sending <= 1'b0;
			byte_index <= 4'h0;
			note_data <= 16'h0000;
			note_out <= '0;
		end else begin
			if (start) begin
				sending <= 1'b1;
				byte_index <= 4'h0;
				note_data <= next_data;
			end else if (last_taken) begin
				sending <= 1'b0;
			end else if (byte_taken) begin
				byte_index <= byte_index + 4'h1;
			end
			// Valid drops for one cycle after each accepted byte so a byte is never repeated.
			note_out.valid <= sending && !byte_taken;
			note_out.data <= packet_byte;
			note_out.last <= byte_index == `NOTE_BYTES - 4'h1;
		end
	end
endmodule
`default_nettype wire

// ---- rtl/gpio_notify_pkg.sv ----
package gpio_notify_pkg;
	typedef struct packed {
		logic overrun;
		logic parity;
		logic framing;
		logic ring;
		logic break_level;
		logic dsr;
		logic carrier;
	} line_state_type;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic last;
	} note_byte_type;
endpackage

// ---- rtl/gpio_notify_regs.svh ----
`ifndef GPIO_NOTIFY_REGS_SVH
`define GPIO_NOTIFY_REGS_SVH

// Register byte offsets on the Wishbone bus.
`define OFS_FUNCTION 8'h00
`define OFS_DIRECTION 8'h04
`define OFS_SET 8'h08
`define OFS_CLEAR 8'h0c
`define OFS_STATUS 8'h10
`define OFS_MASK 8'h14
`define OFS_FORMAT 8'h18
`define OFS_TURNAROUND 8'h1c
`define OFS_LINE 8'h20

// Pin-function codes and field positions.
`define FN_GPIO 3'h0
`define FN_RTS_CTS 3'h1
`define FN_DTR_DSR 3'h2
`define FN_TRANSCEIVER_DIRECTION 3'h3
`define FN_TRANSCEIVER_DIRECTION_ADDR 3'h4
`define POLARITY_BIT 3
`define FORMAT_BIT 0

// Notification header bytes.
`define NOTE_REQUEST_TYPE 8'ha1
`define NOTE_CODE 8'h20
`define NOTE_VALUE 16'h0000
`define NOTE_INTERFACE 8'h00
`define NOTE_LENGTH 16'h0002
`define NOTE_BYTES 4'ha

// Reset values.
`define RESET_FUNCTION 4'h0
`define RESET_DIRECTION 6'h00
`define RESET_LEVELS 6'h00
`define RESET_MASK 6'h00
`define RESET_TURNAROUND 4'h0

`endif

// ---- rtl/pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 6
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic reset_n,
	// Pins in and settled levels out.
	input wire logic [WIDTH-1:0] pin_raw,
	output logic [WIDTH-1:0] pin_level,
	output logic [WIDTH-1:0] pin_changed
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	wire [WIDTH-1:0] agree = ~(stage2 ^ stage3);
	wire [WIDTH-1:0] next_level = (agree & stage3) | (~agree & pin_level);

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			pin_level <= '0;
			pin_changed <= '0;
		end else begin
			stage1 <= pin_raw;
			stage2 <= stage1;
			stage3 <= stage2;
			pin_level <= next_level;
			pin_changed <= next_level ^ pin_level;
		end
	end
endmodule
`default_nettype wire

// ---- tb/gpio_mux_and_serial_state_notify_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "gpio_notify_regs.svh"
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin fails++; \
	$display("CHECK FAILED %s expected %0h seen %0h", n, e, a); end end
module gpio_mux_and_serial_state_notify_bench;
	logic sys_clk = 1'b0, reset_n = 1'b0, cyc = 1'b0, we = 1'b0;
	logic rts = 1'b0, tx = 1'b0, am = 1'b0, tick = 1'b0, ack, ready, cts, dsr;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0, q, rdo;
	logic [5:0] ext = 6'h00, po, oe, lvl;
	logic [2:0] ff;
	gpio_notify_pkg::line_state_type ls = 7'h00;
	gpio_notify_pkg::note_byte_type no;
	int fails = 0, tests_run = 0, cycles = 0, mdir = 0, mout = 0, d;
	int tk[5] = '{6'h0, 6'h30, 6'hc, 6'h20, 6'h20};
	int hdr[8] = '{8'ha1, 8'h20, 8'h0, 8'h0, 8'h0, 8'h0, 8'h2, 8'h0};
	always #4 sys_clk = ~sys_clk;
	// Output pins read back what they drive; inputs read the outside world.
	assign lvl = (oe & po) | (~oe & ext);
	gpio_notify #(.PINS(6)) DUT (.sys_clk, .reset_n, .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(rdo),
		.wb_ack_o(ack), .pin_in(lvl), .pin_out(po), .pin_oe(oe), .cts_level(cts),
		.dsr_level(dsr), .rts_request(rts), .dtr_request(rts), .tx_active(tx),
		.address_match(am), .bit_tick(tick), .flow_function(ff), .line_state(ls),
		.note_ready(ready), .note_out(no));
	notify_host HOST (.sys_clk, .reset_n, .note_out(no), .note_ready(ready));
	task report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			report_and_stop();
		end
	end
	task wb(input logic w, input logic [7:0] a, input logic [31:0] v);
		int n;
		n = 0;
		@(posedge sys_clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= v;
		do begin
			@(posedge sys_clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdo;
		cyc <= 1'b0;
		if (n >= 20)
			fails++;
	endtask
	task settle;
		repeat (8) @(posedge sys_clk);
		#1;
	endtask
	task pkt(input int fmt, input int err);
		int n;
		n = 0;
		while (HOST.got.size() < 10 && n < 300) begin
			@(posedge sys_clk);
			n++;
		end
		d = err | ls.ring << 3 | ls.break_level << 2 | ls.dsr << 1 | ls.carrier;
		if (fmt)
			d |= lvl[5] << 14 | lvl[4] << 13 | lvl[3] << 12 | lvl[0] << 11 | lvl[2] << 9 | lvl[1] << 8;
		for (int i = 0; i < 10; i++)
			`CHK("note byte", 9'(i == 9 ? 'h100 | d[15:8] : i == 8 ? d[7:0] : hdr[i]), HOST.got[i])
		HOST.got.delete();
	endtask
	initial begin
		void'($urandom(83674));
		repeat (6) @(posedge sys_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 10; i++)
			if (i != 3) begin
				wb(1'b0, 8'(i * 4), 32'h0);
				`CHK("reset read", 32'h0, q)
			end
		wb(1'b1, `OFS_MASK, 32'h3f);
		for (int k = 0; k < 6; k++) begin
			mdir = $urandom % 64;
			ext <= 6'($urandom);
			wb(1'b1, `OFS_DIRECTION, mdir);
			settle();
			`CHK("enable", 6'(mdir), oe)
			`CHK("held latch", 6'(mout & mdir), po & oe)
			d = $urandom % 64;
			mout = (mout & ~mdir) | (d & mdir);
			wb(1'b1, `OFS_SET, d);
			d = $urandom % 64;
			mout &= ~(d & mdir);
			wb(1'b1, `OFS_CLEAR, d);
			settle();
			`CHK("drive", 6'(mout & mdir), po & oe)
			wb(1'b0, `OFS_STATUS, 32'h0);
			`CHK("status", 32'(lvl), q)
		end
		wb(1'b1, `OFS_DIRECTION, 32'h3f);
		rts <= 1'b1;
		tx <= 1'b1;
		am <= 1'b1;
		for (int f = 0; f < 5; f++) begin
			wb(1'b1, `OFS_FUNCTION, f | (f % 2) << 3);
			settle();
			wb(1'b0, `OFS_FUNCTION, 32'h0);
			`CHK("function", 32'(f | (f % 2) << 3), q)
			`CHK("mode copy", 3'(f), ff)
			wb(1'b0, `OFS_DIRECTION, 32'h0);
			`CHK("direction", 32'(6'h3f & ~tk[f]), q)
			if (f > 0)
				`CHK("serial pin", 1'(f > 2 ? f % 2 : 0), po[f == 2 ? 3 : 5])
			`CHK("cts copy", f == 1 && lvl[4], cts)
			`CHK("dsr copy", f == 2 && lvl[2], dsr)
		end
		am <= 1'b0;
		settle();
		`CHK("address gate", 1'b1, po[5])
		wb(1'b1, `OFS_TURNAROUND, 32'h3);
		wb(1'b1, `OFS_FUNCTION, `FN_TRANSCEIVER_DIRECTION);
		settle();
		`CHK("direction on", 1'b0, po[5])
		tx <= 1'b0;
		settle();
		for (int t = 0; t < 3; t++) begin
			`CHK("turnaround hold", 1'b0, po[5])
			tick <= 1'b1;
			@(posedge sys_clk);
			tick <= 1'b0;
			settle();
		end
		`CHK("turnaround done", 1'b1, po[5])
		wb(1'b1, `OFS_FUNCTION, 32'h0);
		wb(1'b1, `OFS_DIRECTION, 32'h0);
		settle();
		HOST.got.delete();
		for (int fmt = 0; fmt < 2; fmt++) begin
			wb(1'b1, `OFS_FORMAT, fmt);
			ls.ring <= ~ls.ring;
			pkt(fmt, 0);
		end
		wb(1'b1, `OFS_MASK, 32'h3d);
		ext[1] <= ~ext[1];
		pkt(1, 0);
		ext[2] <= ~ext[2];
		repeat (60) @(posedge sys_clk);
		`CHK("masked pin quiet", 0, HOST.got.size())
		// A one-cycle parity pulse must be reported once, then cleared by the next packet.
		ls.parity <= 1'b1;
		@(posedge sys_clk);
		ls.parity <= 1'b0;
		pkt(1, 'h20);
		{ls.break_level, ls.dsr, ls.carrier} <= 3'h7;
		pkt(1, 0);
		report_and_stop();
	end
endmodule
`default_nettype wire

// ---- tb/gpio_notify_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpio_notify_monitor #(
	parameter int PINS = 6
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic reset_n,
	// Bus and notification stream.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic note_ready,
	input wire gpio_notify_pkg::note_byte_type note_out,
	// Pin control.
	input wire logic [PINS-1:0] pin_oe,
	input wire logic [2:0] flow_function
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	a_note_hold: assert property (note_out.valid && !note_ready |=> note_out.valid && $stable(note_out))
		else $error("byte dropped while stalled");
	a_note_gap: assert property (note_out.valid && note_ready |=> !note_out.valid)
		else $error("no gap after byte");
	a_cts_pins: assert property (flow_function == 3'h1 && $past(flow_function) == 3'h1
		|-> pin_oe[5] && !pin_oe[4])
		else $error("flow pins wrong");
	a_dsr_pins: assert property (flow_function == 3'h2 && $past(flow_function) == 3'h2
		|-> pin_oe[3] && !pin_oe[2])
		else $error("ready pins wrong");
	a_dir_pin: assert property (flow_function == 3'h3 && $past(flow_function) == 3'h3
		|-> pin_oe[5])
		else $error("direction pin not driven");
endmodule
bind gpio_notify gpio_notify_monitor #(.PINS(PINS)) mon (.sys_clk, .reset_n, .wb_cyc_i,
	.wb_stb_i, .wb_ack_o, .wb_dat_o, .note_ready, .note_out, .pin_oe, .flow_function);
`default_nettype wire

// ---- tb/notify_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module notify_host (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic reset_n,
	// Notification stream.
	input wire gpio_notify_pkg::note_byte_type note_out,
	output logic note_ready
);
	// Bytes are kept with the last flag on top; random stalls stand for a busy host.
	logic [8:0] got [$];
	initial note_ready = 1'b0;
	always @(posedge sys_clk) begin
		if (reset_n && note_ready && note_out.valid)
			got.push_back({note_out.last, note_out.data});
		note_ready <= reset_n && ($urandom % 3 != 0);
	end
endmodule
`default_nettype wire
